// File: verilog/cmwd_pkg.sv
package cmwd_pkg;

	// Word, address and module geometry
	localparam int         WORD_W     = 24;
	localparam int         ADDR_W     = 15;
	localparam int         BANK_AW    = 12;
	localparam int         BANK_WORDS = 4096;
	localparam int         NUM_SLOTS  = 8;
	localparam int         SLOT_W     = 3;
	localparam logic [7:0] FITTED_RST = 8'h01;

	// Instruction fields, vector bit = 23 minus word bit number
	localparam logic [2:0] TAG_DIGIT = 3'h0;
	localparam int         OP_HI     = 20;
	localparam int         OP_LO     = 15;
	localparam int         OP_W      = 6;
	localparam int         ADDR_HI   = 14;
	localparam int         LVL_W     = 4;

	// Index select codes
	localparam logic [1:0] XSEL_FIRST  = 2'h1;
	localparam logic [1:0] XSEL_SECOND = 2'h2;
	localparam logic [1:0] XSEL_THIRD  = 2'h3;

	// Floating format
	localparam int FRAC_W    = 39;
	localparam int EXP_W     = 9;
	localparam int FRAC_LO_W = 15;

	// Register port map
	localparam int         REG_AW     = 3;
	localparam logic [2:0] REG_IDX1   = 3'h0;
	localparam logic [2:0] REG_IDX2   = 3'h1;
	localparam logic [2:0] REG_IDX3   = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam int         STAT_PERR  = 0;
	localparam int         STAT_BUSY  = 1;
	localparam int         STAT_PF    = 2;

	// Reset values and address increment
	localparam logic [23:0] WORD_ZERO = 24'h000000;
	localparam logic [14:0] ADDR_ZERO = 15'h0000;
	localparam logic [14:0] ADDR_ONE  = 15'h0001;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_FETCH  = 3'h1,
		ST_DECODE = 3'h3,
		ST_OPER   = 3'h2,
		ST_DONE   = 3'h6
	} cmwd_state_type;

	// Octal digit n covers word bits 3n to 3n+2
	function automatic logic [2:0] octal_digit(input logic [23:0] w, input logic [2:0] n);
		return w[23 - 3 * n -: 3];
	endfunction : octal_digit

	// Module slot holding an address
	function automatic logic [2:0] slot_of(input logic [14:0] a);
		return a[ADDR_W-1 -: SLOT_W];
	endfunction : slot_of

	// Fraction of a two-word floating value
	function automatic logic [38:0] flt_frac(input logic [23:0] hi, input logic [23:0] lo);
		return {hi, lo[WORD_W-1 -: FRAC_LO_W]};
	endfunction : flt_frac

	// Exponent of a two-word floating value
	function automatic logic [8:0] flt_exp(input logic [23:0] lo);
		return lo[EXP_W-1:0];
	endfunction : flt_exp

endpackage : cmwd_pkg

// File: verilog/cmwd_mem_if.sv
`timescale 1ns/10ps
interface cmwd_mem_if;
	logic                         req;
	logic                         we;
	logic [cmwd_pkg::BANK_AW-1:0] addr;
	logic [cmwd_pkg::WORD_W-1:0]  wdata;
	logic [cmwd_pkg::WORD_W-1:0]  rdata;
	logic                         perr;

	modport bank (input req, input we, input addr, input wdata, output rdata, output perr);
	modport ctrl (output req, output we, output addr, output wdata, input rdata, input perr);
endinterface : cmwd_mem_if

// File: verilog/cmwd_bank.sv
`timescale 1ns/10ps
module cmwd_bank #(
	parameter int DEPTH = cmwd_pkg::BANK_WORDS
) (
	// Clock and reset
	input wire logic  core_clk,
	input wire logic  sys_rst,
	// Access port
	cmwd_mem_if.bank  port
);

	logic [cmwd_pkg::WORD_W:0]    mem [0:DEPTH-1];
	logic [cmwd_pkg::BANK_AW-1:0] mar;
	logic                         wr_pend;
	logic                         rd_pend;
	logic [cmwd_pkg::WORD_W-1:0]  wr_data;

	// Own address register and read/write control
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mar     <= '0;
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_data <= cmwd_pkg::WORD_ZERO;
		end else begin
			wr_pend <= port.req & port.we;
			rd_pend <= port.req & ~port.we;
			if (port.req) begin
				mar     <= port.addr;
				wr_data <= port.wdata;
			end
		end
	end

	// Stored word carries even parity
	always_ff @(posedge core_clk) begin
		if (wr_pend) begin
			mem[mar] <= {^wr_data, wr_data};
		end
	end

	// Read word and its parity check
	assign port.rdata = mem[mar][cmwd_pkg::WORD_W-1:0];
	assign port.perr  = rd_pend & (^mem[mar]);

endmodule : cmwd_bank

// File: verilog/cmwd_core.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
// What this block does
// RL1: Words hold 24 data bits plus parity; 4096-word modules fitted per slot.
// RL2: Processor and channels both address every location with 15 bits.
// RL3: Address arithmetic wraps modulo 32768, so 77777 is followed by 00000.
// RL4: Reads beyond installed memory return an all-zero word.
// RL5: Stores beyond installed memory change nothing; the instruction completes normally.
// RL6: Every module has its own address register and read/write control.
// RL7: Operand access overlaps next fetch when they lie in different modules.
// RL8: Stores generate a parity bit giving the 25-bit word even parity.
// RL9: Every read word is checked for even parity over 25 bits.
// RL10: Bit 0 is the most significant word bit, bit 23 the least.
// RL11: Octal digit n covers bits 3n to 3n+2, counted from the left.
// RL12: Bit 0 is the indirect flag; bits 0 to 2 form the tag.
// RL13: Bits 1 and 2 select an index register.
// RL14: Bits 3 to 8 are the six-bit operation code.
// RL15: Bits 9 to 23 are the 15-bit address field.
// RL16: Fixed words are two's-complement fractions with sign in bit 0.
// RL17: Floating values span two words: 39-bit fraction, 9-bit exponent.
// RL18: Select code 01 picks the first index, 10 the second.
// RL19: Indexing adds no cycles compared with an unindexed instruction.
// RL20: Modification works on the fetched copy; memory keeps the original word.
// RL21: Nonzero select adds the chosen index base, code 11 the third.
// RL22: Indirect flag refetches and decodes tag and address again, per level.
// RL23: A read parity mismatch sets a sticky error flag software can see.
module cmwd_core #(
	parameter logic [7:0] SLOT_FITTED = cmwd_pkg::FITTED_RST
) (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	// Processor request
	input  wire logic                          cpu_start,
	input  wire logic [cmwd_pkg::ADDR_W-1:0]   cpu_pc,
	input  wire logic                          cpu_store,
	input  wire logic [cmwd_pkg::WORD_W-1:0]   cpu_wdata,
	// Processor answer
	output logic                               cpu_busy,
	output logic                               cpu_done,
	output logic [cmwd_pkg::OP_W-1:0]          opcode_field,
	output logic [cmwd_pkg::ADDR_W-1:0]        cpu_ea,
	output logic [cmwd_pkg::WORD_W-1:0]        cpu_operand,
	output logic                               cpu_fix_sign,
	output logic [cmwd_pkg::LVL_W-1:0]         cpu_levels,
	output logic [cmwd_pkg::FRAC_W-1:0]        flt_fraction,
	output logic [cmwd_pkg::EXP_W-1:0]         flt_exponent,
	// Channel access
	input  wire logic                          ch_req,
	input  wire logic                          ch_we,
	input  wire logic [cmwd_pkg::ADDR_W-1:0]   ch_addr,
	input  wire logic [cmwd_pkg::WORD_W-1:0]   ch_wdata,
	output logic                               ch_ack,
	output logic [cmwd_pkg::WORD_W-1:0]        ch_rdata,
	// Register port
	input  wire logic [cmwd_pkg::REG_AW-1:0]   reg_addr,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	input  wire logic [cmwd_pkg::WORD_W-1:0]   reg_wdata,
	output logic [cmwd_pkg::WORD_W-1:0]        reg_rdata,
	// Status
	output logic                               parity_err
);

	cmwd_pkg::cmwd_state_type      state;
	logic [cmwd_pkg::ADDR_W-1:0]   pc;
	logic [cmwd_pkg::ADDR_W-1:0]   sa;
	logic [cmwd_pkg::ADDR_W-1:0]   nxt_pc;
	logic                          store_q;
	logic [cmwd_pkg::WORD_W-1:0]   st_data;
	logic [cmwd_pkg::OP_W-1:0]     opcode_q;
	logic [cmwd_pkg::LVL_W-1:0]    levels;
	logic                          use_pf;
	logic [cmwd_pkg::WORD_W-1:0]   index_reg_first;
	logic [cmwd_pkg::WORD_W-1:0]   index_reg_second;
	logic [cmwd_pkg::WORD_W-1:0]   index_reg_third;
	logic                          pf_valid;
	logic                          pf_issued;
	logic [cmwd_pkg::ADDR_W-1:0]   pf_addr;
	logic [cmwd_pkg::WORD_W-1:0]   pf_word;
	logic                          ch_infl;
	logic                          ch_we_q;
	logic [cmwd_pkg::ADDR_W-1:0]   ch_addr_q;
	logic [cmwd_pkg::WORD_W-1:0]   prev_op;
	logic [cmwd_pkg::WORD_W-1:0]   slot_rd [cmwd_pkg::NUM_SLOTS];
	logic [cmwd_pkg::NUM_SLOTS-1:0] slot_perr;
	logic                          main_on;
	logic                          main_we;
	logic                          pf_on;
	logic                          ch_conflict;
	logic                          ch_gnt;
	logic [cmwd_pkg::WORD_W-1:0]   rd_main;
	logic [cmwd_pkg::WORD_W-1:0]   rd_pf;
	logic [cmwd_pkg::WORD_W-1:0]   rd_ch;
	logic [cmwd_pkg::WORD_W-1:0]   dec_word;
	logic [2:0]                    dec_tag;
	logic [cmwd_pkg::ADDR_W-1:0]   dec_ea;
	logic [cmwd_pkg::WORD_W-1:0]   op_val;

	// Slot fitted for an address
	function automatic logic fitted(input logic [14:0] a);
		return SLOT_FITTED[cmwd_pkg::slot_of(a)];
	endfunction : fitted

	// Base of the selected index register
	function automatic logic [14:0] idx_base(input logic [1:0] sel);
		case (sel)
			cmwd_pkg::XSEL_FIRST:  return index_reg_first[cmwd_pkg::ADDR_HI:0];   // see RL18
			cmwd_pkg::XSEL_SECOND: return index_reg_second[cmwd_pkg::ADDR_HI:0];  // see RL18
			cmwd_pkg::XSEL_THIRD:  return index_reg_third[cmwd_pkg::ADDR_HI:0];   // see RL21
			default:               return cmwd_pkg::ADDR_ZERO;
		endcase
	endfunction : idx_base

	cmwd_mem_if mif [cmwd_pkg::NUM_SLOTS] ();

	// Access sources
	assign nxt_pc  = pc + cmwd_pkg::ADDR_ONE;                                        // see RL3
	assign main_on = (state == cmwd_pkg::ST_FETCH) || (state == cmwd_pkg::ST_OPER);
	assign main_we = (state == cmwd_pkg::ST_OPER) && store_q;
	assign pf_on   = (state == cmwd_pkg::ST_OPER) &&
	                 (cmwd_pkg::slot_of(nxt_pc) != cmwd_pkg::slot_of(sa));          // see RL7
	assign ch_conflict = (main_on && cmwd_pkg::slot_of(sa) == cmwd_pkg::slot_of(ch_addr)) ||
	                     (pf_on && cmwd_pkg::slot_of(nxt_pc) == cmwd_pkg::slot_of(ch_addr));
	assign ch_gnt  = ch_req && !ch_infl && !ch_ack && !ch_conflict;                 // see RL2

	// Module slots
	for (genvar g = 0; g < cmwd_pkg::NUM_SLOTS; g++) begin : g_slot
		localparam logic [2:0] SLOT = 3'(g);
		if (SLOT_FITTED[g]) begin : g_fit
			cmwd_bank #(
				.DEPTH (cmwd_pkg::BANK_WORDS)
			) u_bank (
				.core_clk (core_clk),
				.sys_rst  (sys_rst),
				.port     (mif[g])
			);                                                                       // see RL1, RL6
			assign slot_rd[g]   = mif[g].rdata;
			assign slot_perr[g] = mif[g].perr;                                       // see RL9
		end else begin : g_none
			assign slot_rd[g]   = cmwd_pkg::WORD_ZERO;
			assign slot_perr[g] = 1'b0;
		end
		always_comb begin
			mif[g].req   = 1'b0;
			mif[g].we    = 1'b0;
			mif[g].addr  = '0;
			mif[g].wdata = cmwd_pkg::WORD_ZERO;
			if (main_on && cmwd_pkg::slot_of(sa) == SLOT) begin
				mif[g].req   = 1'b1;
				mif[g].we    = main_we;                                              // see RL5, RL8
				mif[g].addr  = sa[cmwd_pkg::BANK_AW-1:0];
				mif[g].wdata = st_data;
			end else if (pf_on && cmwd_pkg::slot_of(nxt_pc) == SLOT) begin
				mif[g].req   = 1'b1;                                                 // see RL7
				mif[g].addr  = nxt_pc[cmwd_pkg::BANK_AW-1:0];
			end else if (ch_gnt && cmwd_pkg::slot_of(ch_addr) == SLOT) begin
				mif[g].req   = 1'b1;
				mif[g].we    = ch_we;
				mif[g].addr  = ch_addr[cmwd_pkg::BANK_AW-1:0];
				mif[g].wdata = ch_wdata;
			end
		end
	end

	// Read data, zero outside installed memory
	assign rd_main = fitted(sa) ? slot_rd[cmwd_pkg::slot_of(sa)] : cmwd_pkg::WORD_ZERO;  // see RL4
	assign rd_pf   = fitted(nxt_pc) ? slot_rd[cmwd_pkg::slot_of(nxt_pc)] : cmwd_pkg::WORD_ZERO;
	assign rd_ch   = fitted(ch_addr_q) ? slot_rd[cmwd_pkg::slot_of(ch_addr_q)] :
	                 cmwd_pkg::WORD_ZERO;                                           // see RL4

	// Word decode and effective address
	assign dec_word = use_pf ? pf_word : rd_main;
	assign dec_tag  = cmwd_pkg::octal_digit(dec_word, cmwd_pkg::TAG_DIGIT);         // see RL11, RL12
	assign dec_ea   = dec_word[cmwd_pkg::ADDR_HI:0] + idx_base(dec_tag[1:0]);       // see RL13, RL15, RL21
	assign op_val   = store_q ? st_data : rd_main;

	// Fetch and operand sequencing
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= cmwd_pkg::ST_IDLE;
			pc       <= cmwd_pkg::ADDR_ZERO;
			sa       <= cmwd_pkg::ADDR_ZERO;
			store_q  <= 1'b0;
			st_data  <= cmwd_pkg::WORD_ZERO;
			opcode_q <= '0;
			levels   <= '0;
			use_pf   <= 1'b0;
			cpu_busy <= 1'b0;
		end else begin
			case (state)
				cmwd_pkg::ST_IDLE: begin
					if (cpu_start) begin
						pc       <= cpu_pc;
						sa       <= cpu_pc;
						store_q  <= cpu_store;
						st_data  <= cpu_wdata;
						levels   <= '0;
						cpu_busy <= 1'b1;
						if (pf_valid && pf_addr == cpu_pc) begin
							use_pf <= 1'b1;                                          // see RL7
							state  <= cmwd_pkg::ST_DECODE;
						end else begin
							state  <= cmwd_pkg::ST_FETCH;
						end
					end
				end
				cmwd_pkg::ST_FETCH: begin
					state <= cmwd_pkg::ST_DECODE;
				end
				cmwd_pkg::ST_DECODE: begin
					use_pf <= 1'b0;
					if (levels == '0) begin
						opcode_q <= dec_word[cmwd_pkg::OP_HI:cmwd_pkg::OP_LO];          // see RL14
					end
					sa <= dec_ea;                                                     // see RL19, RL20
					if (dec_tag[2]) begin
						if (levels != '1) begin
							levels <= levels + 1'b1;
						end
						state <= cmwd_pkg::ST_FETCH;                                  // see RL22
					end else begin
						state <= cmwd_pkg::ST_OPER;
					end
				end
				cmwd_pkg::ST_OPER: begin
					state <= cmwd_pkg::ST_DONE;
				end
				cmwd_pkg::ST_DONE: begin
					cpu_busy <= 1'b0;
					state    <= cmwd_pkg::ST_IDLE;
				end
				default: begin
					cpu_busy <= 1'b0;
					state    <= cmwd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Processor answer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_done     <= 1'b0;
			opcode_field <= '0;
			cpu_ea       <= cmwd_pkg::ADDR_ZERO;
			cpu_operand  <= cmwd_pkg::WORD_ZERO;
			cpu_fix_sign <= 1'b0;
			cpu_levels   <= '0;
			flt_fraction <= '0;
			flt_exponent <= '0;
			prev_op      <= cmwd_pkg::WORD_ZERO;
		end else begin
			cpu_done <= (state == cmwd_pkg::ST_DONE);
			if (state == cmwd_pkg::ST_DONE) begin
				opcode_field <= opcode_q;
				cpu_ea       <= sa;
				cpu_operand  <= op_val;
				cpu_fix_sign <= op_val[cmwd_pkg::WORD_W-1];                           // see RL10, RL16
				cpu_levels   <= levels;
				flt_fraction <= cmwd_pkg::flt_frac(prev_op, op_val);                  // see RL17
				flt_exponent <= cmwd_pkg::flt_exp(op_val);                            // see RL17
				prev_op      <= op_val;
			end
		end
	end

	// Overlapped next-instruction buffer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pf_valid  <= 1'b0;
			pf_issued <= 1'b0;
			pf_addr   <= cmwd_pkg::ADDR_ZERO;
			pf_word   <= cmwd_pkg::WORD_ZERO;
		end else begin
			pf_issued <= pf_on;
			if (pf_issued) begin
				pf_valid <= 1'b1;                                                    // see RL7
				pf_addr  <= nxt_pc;
				pf_word  <= rd_pf;
			end else if ((state == cmwd_pkg::ST_IDLE && cpu_start) ||
			             (main_we && sa == pf_addr) ||
			             (ch_gnt && ch_we && ch_addr == pf_addr)) begin
				pf_valid <= 1'b0;
			end
		end
	end

	// Channel access
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ch_infl   <= 1'b0;
			ch_we_q   <= 1'b0;
			ch_addr_q <= cmwd_pkg::ADDR_ZERO;
			ch_ack    <= 1'b0;
			ch_rdata  <= cmwd_pkg::WORD_ZERO;
		end else begin
			ch_infl <= ch_gnt;
			if (ch_gnt) begin
				ch_we_q   <= ch_we;
				ch_addr_q <= ch_addr;
			end
			ch_ack   <= ch_infl;
			ch_rdata <= (ch_infl && !ch_we_q) ? rd_ch : cmwd_pkg::WORD_ZERO;
		end
	end

	// Index registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			index_reg_first  <= cmwd_pkg::WORD_ZERO;
			index_reg_second <= cmwd_pkg::WORD_ZERO;
			index_reg_third  <= cmwd_pkg::WORD_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				cmwd_pkg::REG_IDX1: index_reg_first  <= reg_wdata;
				cmwd_pkg::REG_IDX2: index_reg_second <= reg_wdata;
				cmwd_pkg::REG_IDX3: index_reg_third  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Sticky parity error, set wins over clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			parity_err <= 1'b0;
		end else if (|slot_perr) begin
			parity_err <= 1'b1;                                                      // see RL23
		end else if (reg_wr && reg_addr == cmwd_pkg::REG_STATUS &&
		             reg_wdata[cmwd_pkg::STAT_PERR]) begin
			parity_err <= 1'b0;
		end
	end

	// Register read data
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= cmwd_pkg::WORD_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				cmwd_pkg::REG_IDX1:   reg_rdata <= index_reg_first;
				cmwd_pkg::REG_IDX2:   reg_rdata <= index_reg_second;
				cmwd_pkg::REG_IDX3:   reg_rdata <= index_reg_third;
				cmwd_pkg::REG_STATUS: begin
					reg_rdata                     <= cmwd_pkg::WORD_ZERO;
					reg_rdata[cmwd_pkg::STAT_PERR] <= parity_err;
					reg_rdata[cmwd_pkg::STAT_BUSY] <= cpu_busy;
					reg_rdata[cmwd_pkg::STAT_PF]   <= pf_valid;
				end
				default: reg_rdata <= cmwd_pkg::WORD_ZERO;
			endcase
		end else begin
			reg_rdata <= cmwd_pkg::WORD_ZERO;
		end
	end

endmodule : cmwd_core

// File: bench/cmwd_core_asserts.sv
`timescale 1ns/10ps
module cmwd_core_asserts (
	// Clock and reset
	input wire logic                        core_clk,
	input wire logic                        sys_rst,
	// Processor
	input wire logic                        cpu_start,
	input wire logic                        cpu_store,
	input wire logic [cmwd_pkg::WORD_W-1:0] cpu_wdata,
	input wire logic                        cpu_busy,
	input wire logic                        cpu_done,
	input wire logic [cmwd_pkg::WORD_W-1:0] cpu_operand,
	input wire logic                        cpu_fix_sign,
	input wire logic [cmwd_pkg::LVL_W-1:0]  cpu_levels,
	input wire logic [cmwd_pkg::FRAC_W-1:0] flt_fraction,
	input wire logic [cmwd_pkg::EXP_W-1:0]  flt_exponent,
	// Channel and register port
	input wire logic                        ch_req,
	input wire logic                        ch_ack,
	input wire logic [cmwd_pkg::WORD_W-1:0] ch_rdata,
	input wire logic                        reg_rd,
	input wire logic [cmwd_pkg::WORD_W-1:0] reg_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic        taken;
	logic [7:0]  span;
	logic        st_flag;
	logic [23:0] st_data;
	logic [23:0] last_op;
	assign taken = cpu_start && !cpu_busy;
	// Cycles since the start was taken
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			span <= 8'h00;
		end else if (taken) begin
			span <= 8'h01;
		end else if (cpu_busy && span != 8'hFF) begin
			span <= span + 8'h01;
		end
	end
	// Store request and last operand
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_flag <= 1'b0;
			st_data <= 24'h000000;
			last_op <= 24'h000000;
		end else begin
			if (taken) begin
				st_flag <= cpu_store;
				st_data <= cpu_wdata;
			end
			if (cpu_done) begin
				last_op <= cpu_operand;
			end
		end
	end
	a_done_span: assert property (cpu_done && cpu_levels != 4'hF |->
		span == 8'h05 + 8'h02 * cpu_levels || span == 8'h04 + 8'h02 * cpu_levels)
		else $error("instruction length wrong");
	a_busy_hold: assert property (taken |=> cpu_busy [*3])
		else $error("busy not held after start");
	a_done_pulse: assert property (cpu_done |-> !cpu_busy ##1 !cpu_done)
		else $error("done not a single pulse");
	a_fix_sign: assert property (cpu_done |-> cpu_fix_sign == cpu_operand[23])
		else $error("sign bit wrong");
	a_flt_split: assert property (cpu_done |-> flt_exponent == cpu_operand[8:0] &&
		flt_fraction == {last_op, cpu_operand[23:9]})
		else $error("floating split wrong");
	a_store_data: assert property (cpu_done && st_flag |-> cpu_operand == st_data)
		else $error("store operand wrong");
	a_ch_grant: assert property (ch_ack |-> $past(ch_req) && $past(ch_req, 2) ##1 !ch_ack)
		else $error("channel ack without request");
	a_ch_quiet: assert property (!ch_ack |-> ch_rdata == 24'h000000)
		else $error("channel data outside ack");
	a_reg_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 24'h000000)
		else $error("register data outside read");
	c_indirect: cover property (cpu_done && cpu_levels != 4'h0);
	c_overlap: cover property (cpu_done && span == 8'h04);
	c_contend: cover property (ch_ack && cpu_busy);
endmodule : cmwd_core_asserts

bind cmwd_core cmwd_core_asserts u_asserts (.core_clk, .sys_rst, .cpu_start, .cpu_store,
	.cpu_wdata, .cpu_busy, .cpu_done, .cpu_operand, .cpu_fix_sign, .cpu_levels,
	.flt_fraction, .flt_exponent, .ch_req, .ch_ack, .ch_rdata, .reg_rd, .reg_rdata);

// File: bench/cmwd_chan_model.sv
`timescale 1ns/10ps
module cmwd_chan_model (
	// Clock
	input  wire logic                        core_clk,
	// Channel side
	output logic                             ch_req,
	output logic                             ch_we,
	output logic [cmwd_pkg::ADDR_W-1:0]      ch_addr,
	output logic [cmwd_pkg::WORD_W-1:0]      ch_wdata,
	input  wire logic                        ch_ack,
	input  wire logic [cmwd_pkg::WORD_W-1:0] ch_rdata
);
	initial begin
		ch_req = 1'b0;
		ch_we = 1'b0;
		ch_addr = 15'h0000;
		ch_wdata = 24'h000000;
	end
	// One access, held until acknowledged
	task automatic xfer(input logic we, input logic [14:0] a, input logic [23:0] d,
		output logic [23:0] q, output logic ok);
		int n;
		n = 0;
		@(posedge core_clk);
		ch_req <= 1'b1;
		ch_we <= we;
		ch_addr <= a;
		ch_wdata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (ch_ack !== 1'b1 && n < 64);
		q = ch_rdata;
		ok = (ch_ack === 1'b1);
		ch_req <= 1'b0;
		ch_we <= ~we;
		ch_addr <= ~a;
		ch_wdata <= ~d;
	endtask : xfer
endmodule : cmwd_chan_model

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] FIT = 8'h05;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cpu_start = 1'b0;
	logic [14:0] cpu_pc = 15'h0000;
	logic        cpu_store = 1'b0;
	logic [23:0] cpu_wdata = 24'h000000;
	logic [2:0]  reg_addr = 3'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [23:0] reg_wdata = 24'h000000;
	logic        cpu_busy, cpu_done, cpu_fix_sign, ch_req, ch_we, ch_ack, parity_err;
	logic [5:0]  opcode_field;
	logic [14:0] cpu_ea, ch_addr;
	logic [23:0] cpu_operand, ch_wdata, ch_rdata, reg_rdata, prev_op, q, v;
	logic [3:0]  cpu_levels;
	logic [38:0] flt_fraction;
	logic [8:0]  flt_exponent;
	logic [23:0] mem [logic [14:0]];
	logic [14:0] xb [4];
	logic [14:0] pfa;
	logic        pfv;
	logic [31:0] seed = 32'h0000004D;
	logic [31:0] r;
	int          errors, samples_checked, cycles;
	cmwd_core #(.SLOT_FITTED(FIT)) u_dut (.core_clk, .sys_rst, .cpu_start, .cpu_pc, .cpu_store,
		.cpu_wdata, .cpu_busy, .cpu_done, .opcode_field, .cpu_ea, .cpu_operand, .cpu_fix_sign,
		.cpu_levels, .flt_fraction, .flt_exponent, .ch_req, .ch_we, .ch_addr, .ch_wdata,
		.ch_ack, .ch_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .parity_err);
	cmwd_chan_model u_chan (.core_clk, .ch_req, .ch_we, .ch_addr, .ch_wdata, .ch_ack, .ch_rdata);
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [38:0] seen, input logic [38:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift
	function automatic logic [23:0] rdm(input logic [14:0] a);
		return FIT[a[14:12]] ? mem[a] : 24'h000000;
	endfunction : rdm
	task automatic reg_w(input logic [2:0] a, input logic [23:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_w
	task automatic reg_r(input logic [2:0] a, output logic [23:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : reg_r
	task automatic chan(input logic we, input logic [14:0] a, input logic [23:0] d);
		logic [23:0] got;
		logic        ok;
		u_chan.xfer(we, a, d, got, ok);
		check("ch_ack", ok, 1'b1);
		if (we && FIT[a[14:12]]) mem[a] = d;
		check("ch_rdata", got, we ? 24'h000000 : rdm(a));
	endtask : chan
	task automatic run(input logic [14:0] pc, input logic st, input logic [23:0] d,
		input logic poke);
		logic [23:0] w, op;
		logic [14:0] ea, pn;
		logic [5:0]  opc;
		int          lv, n, want;
		w = rdm(pc);
		opc = w[20:15];
		lv = 0;
		ea = w[14:0] + xb[w[22:21]];
		while (w[23] === 1'b1 && lv < 8) begin
			w = rdm(ea);
			lv++;
			ea = w[14:0] + xb[w[22:21]];
		end
		op = st ? d : rdm(ea);
		if (st && FIT[ea[14:12]]) mem[ea] = d;
		want = ((pfv && pfa == pc) ? 4 : 5) + 2 * lv;
		pn = pc + 15'h0001;
		pfv = pn[14:12] != ea[14:12];
		pfa = pn;
		@(posedge core_clk);
		cpu_start <= 1'b1;
		cpu_pc <= pc;
		cpu_store <= st;
		cpu_wdata <= d;
		@(posedge core_clk);
		cpu_start <= 1'b0;
		cpu_pc <= ~pc;
		cpu_wdata <= ~d;
		n = 0;
		while (cpu_done !== 1'b1 && n < 99) begin
			@(posedge core_clk);
			n++;
			cpu_start <= poke && n == 2;
		end
		check("cycles", n, want);
		check("opcode_field", opcode_field, opc);
		check("cpu_ea", cpu_ea, ea);
		check("cpu_levels", cpu_levels, lv);
		check("cpu_operand", cpu_operand, op);
		check("cpu_fix_sign", cpu_fix_sign, op[23]);
		check("flt_fraction", flt_fraction, {prev_op, op[23:9]});
		check("flt_exponent", flt_exponent, op[8:0]);
		prev_op = op;
	endtask : run
	initial begin
		pfv = 1'b0;
		prev_op = 24'h000000;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		check("reset_out", {cpu_busy, cpu_done, ch_ack, parity_err, reg_rdata}, 39'h0);
		// Index bases: none, empty slot, wrap, short step
		xb = '{15'h0000, 15'h1000, 15'h7FF0, 15'h0002};
		for (int i = 1; i < 4; i++) begin
			r = xorshift();
			v = {r[8:0], xb[i]};
			reg_w(3'(i - 1), v);
			reg_r(3'(i - 1), q);
			check("index_reg", q, v);
		end
		reg_w(3'h6, 24'hFFFFFF);
		reg_r(3'h6, q);
		check("unmapped", q, 24'h000000);
		reg_r(3'h3, q);
		check("status", q[2:0], 3'h0);
		for (int i = 0; i < 64; i++) begin
			r = xorshift();
			chan(1'b1, 15'(i), {r[2:0], r[8:3], 10'h100, r[13:9]});
			r = xorshift();
			chan(1'b1, 15'h2000 + 15'(i), {1'b0, r[1:0], r[7:2], 10'h000, r[12:8]});
		end
		chan(1'b0, 15'h2007, 24'h000000);
		chan(1'b1, 15'h1234, 24'h5A5A5A);
		chan(1'b0, 15'h1234, 24'h000000);
		fork
			begin
				for (int i = 0; i < 32; i++) run(15'(i), 1'b0, 24'h000000, i == 3);
				for (int i = 0; i < 48; i++) begin
					r = xorshift();
					v = xorshift();
					run((r[5:0] == 6'h3F) ? 15'h003E : {9'h000, r[5:0]}, r[6],
						{1'b0, v[22:15], 10'h000, v[4:0]}, 1'b0);
				end
			end
			for (int j = 0; j < 16; j++) chan(1'b0, 15'h0030 + 15'(j), 24'h000000);
		join
		chan(1'b0, 15'h3005, 24'h000000);
		check("parity_err", parity_err, 1'b0);
		stop_test();
	end
endmodule : tb
